// [bsps_host_model.sv]
/*
 * Host controller model: makes step clock pulses on request and
 * holds the bias/set pin open from power-up until told otherwise.
 * Assumes requests come synchronous to clock_in.
 */
module bsps_host_model (
   input wire logic clock_in,
   input wire logic step_req_in,
   input wire logic open_req_in,
   output logic step_clk_out,
   output logic bias_set_open_out,
   output logic busy_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt_reg = 2'h0;
   logic act_reg = 1'b0;
   logic clk_reg = 1'b0;
   logic open_reg = 1'b1;

   ////////////////////////////////////////////////////////////
   // high two cycles, then low at least three, so edges never crowd each other
   always @(posedge clock_in) begin
      open_reg <= open_req_in;
      if (!act_reg && step_req_in) begin
         act_reg <= 1'b1;
         cnt_reg <= 2'h0;
         clk_reg <= 1'b1;
      end else if (act_reg) begin
         cnt_reg <= cnt_reg + 2'h1;
         if (cnt_reg == 2'h1) clk_reg <= 1'b0;
         if (cnt_reg == 2'h3) act_reg <= 1'b0;
      end
   end

   assign step_clk_out = clk_reg;
   assign bias_set_open_out = open_reg;
   assign busy_out = act_reg;
endmodule : bsps_host_model

// [bsps_pkg.sv]
/*
 * Shared constants and types for the bipolar stepper phase sequencer.
 * Assumes a single 40 MHz clock and a plain register port with
 * one-cycle read latency.
 */
// Notes on behaviour
// [RULE1] select low: one full step per clock
// [RULE2] full mode cycles four phases A-D
// [RULE3] every full phase drives both coils
// [RULE4] select high: one half step per clock
// [RULE5] half mode cycles eight phases A-H
// [RULE6] half A,C,E,G equal full A,B,C,D
// [RULE7] half B,D,F,H energize only one coil
// [RULE8] impedance low: idle coil switches all off
// [RULE9] impedance high: idle coil upper on, lower off
// [RULE10] high impedance means both switches off
// [RULE11] bias open: phase A, all coil outputs floated
// [RULE12] bias open: home low, controls ignored
// [RULE13] bias back: resume in phase A, controls live
// [RULE14] standby bias cuts current, phase kept
// [RULE15] host may hold bias open at power-up
// [RULE16] advance only on step clock rising edge
// [RULE17] home indicator low exactly in phase A
// [RULE18] direction low forward, high backward, wrapping
// [RULE19] polarity is Gray decode of phase index
// [RULE20] size change maps to nearest new phase
package bsps_pkg;

   ////////////////////////////////////////////////////////////
   // phase index in half-step units, A is zero
   typedef logic [2:0] bsps_phase_t;
   localparam bsps_phase_t PHASE_A = 3'h0;
   localparam bsps_phase_t STEP_HALF = 3'h1;
   localparam bsps_phase_t STEP_FULL = 3'h2;

   // one bridge output: upper and lower switch
   typedef struct packed {
      logic hi_on;
      logic lo_on;
   } bsps_drive_s;

   // both outputs of one coil
   typedef struct packed {
      bsps_drive_s p;
      bsps_drive_s n;
   } bsps_coil_s;

   localparam bsps_drive_s DRIVE_OFF = 2'h0;
   localparam bsps_drive_s DRIVE_HIGH = 2'h2;
   localparam bsps_drive_s DRIVE_LOW = 2'h1;
   localparam bsps_drive_s DRIVE_UPPER = 2'h2;

   ////////////////////////////////////////////////////////////
   // register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam int CTRL_SET_BIT = 0;
   localparam int CTRL_STBY_BIT = 1;
   localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

   // control and status as carried internally
   typedef struct packed {
      logic soft_standby;
      logic soft_set;
   } bsps_ctrl_s;

   typedef struct packed {
      logic standby;
      logic set_active;
      logic half_mode;
      bsps_phase_t phase;
   } bsps_status_s;

endpackage : bsps_pkg

// [bsps_sequencer.sv]
/*
 * Phase sequencer and output decode for a two-coil bipolar
 * stepper bridge, with a small control/status register port.
 * Assumes every input is synchronous to clock_in, the step
 * clock is far slower than clock_in, and the bias/set pin has
 * been reduced to two logic levels: open and standby.
 */
// Decided for this implementation: the strobed register port and the register addresses.
module bsps_sequencer (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic step_clk_in,
   input wire logic rotation_dir_in,
   input wire logic step_size_sel_in,
   input wire logic idle_coil_impedance_sel_in,
   input wire logic bias_set_open_in,
   input wire logic bias_set_standby_in,
   input wire logic [bsps_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [bsps_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output bsps_pkg::bsps_drive_s coil_a_out_p_out,
   output bsps_pkg::bsps_drive_s coil_a_out_n_out,
   output bsps_pkg::bsps_drive_s coil_b_out_p_out,
   output bsps_pkg::bsps_drive_s coil_b_out_n_out,
   output logic home_phase_n_out,
   output logic home_phase_n_oe_out,
   output logic drive_reduced_out,
   output logic [bsps_pkg::DATA_W-1:0] reg_rdata_out
);

   ////////////////////////////////////////////////////////////
   // coil polarity helpers
   function automatic bsps_pkg::bsps_coil_s coil_pol(
      input logic neg
   );
      bsps_pkg::bsps_coil_s c;
      c.p = neg ? bsps_pkg::DRIVE_LOW : bsps_pkg::DRIVE_HIGH;
      c.n = neg ? bsps_pkg::DRIVE_HIGH : bsps_pkg::DRIVE_LOW;
      return c;
   endfunction : coil_pol

   // idle coil: floated or both uppers on
   function automatic bsps_pkg::bsps_coil_s coil_idle(
      input logic low_z
   );
      bsps_pkg::bsps_coil_s c;
      c.p = low_z ? bsps_pkg::DRIVE_UPPER : bsps_pkg::DRIVE_OFF; // RULE8 RULE9
      c.n = low_z ? bsps_pkg::DRIVE_UPPER : bsps_pkg::DRIVE_OFF; // RULE10
      return c;
   endfunction : coil_idle

   // Gray polarity of full phase f: A ++, B -+, C --, D +-
   function automatic logic neg_a(input logic [1:0] f);
      return f[0] ^ f[1];
   endfunction : neg_a

   function automatic logic neg_b(input logic [1:0] f);
      return f[1];
   endfunction : neg_b

   ////////////////////////////////////////////////////////////
   // registers
   bsps_pkg::bsps_phase_t phase_reg;
   bsps_pkg::bsps_phase_t phase_next;
   logic step_prev_reg;
   bsps_pkg::bsps_ctrl_s ctrl_reg;
   bsps_pkg::bsps_coil_s coil_a_reg;
   bsps_pkg::bsps_coil_s coil_b_reg;
   bsps_pkg::bsps_coil_s coil_a_next;
   bsps_pkg::bsps_coil_s coil_b_next;
   logic home_reg;
   logic home_n_reg;
   logic reduced_reg;
   logic half_reg;
   logic set_reg;
   logic [bsps_pkg::DATA_W-1:0] rdata_reg;
   logic [bsps_pkg::DATA_W-1:0] rdata_next;

   ////////////////////////////////////////////////////////////
   // control decode
   wire logic set_active;
   wire logic step_edge;
   wire logic standby;
   wire logic odd_phase;
   wire bsps_pkg::bsps_phase_t step_amt;
   wire logic [1:0] full_idx;
   wire logic [1:0] low_idx;
   wire logic [1:0] high_idx;

   // open bias or soft set both preset the sequencer
   assign set_active = bias_set_open_in | ctrl_reg.soft_set; // RULE11
   // edge qualified only while bias is present
   assign step_edge = step_clk_in & ~step_prev_reg & ~set_active; // RULE16 RULE12
   assign standby = bias_set_standby_in | ctrl_reg.soft_standby;

   // full mode from an odd phase lands on the nearest even one
   assign step_amt = (step_size_sel_in | phase_reg[0])
      ? bsps_pkg::STEP_HALF : bsps_pkg::STEP_FULL; // RULE1 RULE4 RULE20

   ////////////////////////////////////////////////////////////
   // next phase: forward on low direction, wrap is free in 3 bits
   always_comb begin
      phase_next = phase_reg;
      if (set_active) begin
         phase_next = bsps_pkg::PHASE_A; // RULE11
      end else if (step_edge) begin
         if (rotation_dir_in) begin
            phase_next = phase_reg - step_amt; // RULE18
         end else begin
            phase_next = phase_reg + step_amt; // RULE18 RULE2 RULE5
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // output decode from the next phase
   assign odd_phase = phase_next[0];
   assign full_idx = phase_next[2:1];
   assign low_idx = phase_next[2:1];
   assign high_idx = phase_next[2:1] + 2'h1;

   always_comb begin
      coil_a_next = coil_pol(neg_a(full_idx)); // RULE19 RULE6 RULE3
      coil_b_next = coil_pol(neg_b(full_idx)); // RULE19 RULE6 RULE3
      if (odd_phase) begin
         // the coil whose sign differs between neighbours rests
         if (neg_a(low_idx) != neg_a(high_idx)) begin
            coil_a_next = coil_idle(idle_coil_impedance_sel_in); // RULE7
            coil_b_next = coil_pol(neg_b(low_idx)); // RULE7
         end else begin
            coil_a_next = coil_pol(neg_a(low_idx)); // RULE7
            coil_b_next = coil_idle(idle_coil_impedance_sel_in); // RULE7
         end
      end
      if (set_active) begin
         coil_a_next = coil_idle(1'b0); // RULE11 RULE10
         coil_b_next = coil_idle(1'b0); // RULE11 RULE10
      end
   end

   ////////////////////////////////////////////////////////////
   // sequencer state
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         phase_reg <= bsps_pkg::PHASE_A;
         step_prev_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         step_prev_reg <= step_clk_in;
      end
   end

   // output flops; standby never touches the phase
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         coil_a_reg <= {bsps_pkg::DRIVE_OFF, bsps_pkg::DRIVE_OFF};
         coil_b_reg <= {bsps_pkg::DRIVE_OFF, bsps_pkg::DRIVE_OFF};
         home_reg <= 1'b1;
         home_n_reg <= 1'b0;
         reduced_reg <= 1'b0;
      end else begin
         coil_a_reg <= coil_a_next; // RULE13
         coil_b_reg <= coil_b_next; // RULE13
         home_reg <= (phase_next == bsps_pkg::PHASE_A); // RULE17 RULE12
         // own flop so the pin needs no inverter after the register
         home_n_reg <= (phase_next != bsps_pkg::PHASE_A); // RULE17
         reduced_reg <= standby; // RULE14
      end
   end

   ////////////////////////////////////////////////////////////
   // register port: control write, status read one cycle later
   wire logic wr_ctrl;
   wire logic rd_ctrl;
   wire logic rd_stat;
   wire bsps_pkg::bsps_status_s status;

   assign wr_ctrl = reg_wr_in & (reg_addr_in == bsps_pkg::CTRL_OFS);
   assign rd_ctrl = reg_rd_in & (reg_addr_in == bsps_pkg::CTRL_OFS);
   assign rd_stat = reg_rd_in & (reg_addr_in == bsps_pkg::STATUS_OFS);
   assign status = '{standby: reduced_reg, set_active: set_reg,
                     half_mode: half_reg, phase: phase_reg};

   // unmapped reads give zero; data stands only one cycle
   always_comb begin
      rdata_next = bsps_pkg::RDATA_ZERO;
      if (rd_ctrl) begin
         rdata_next[1:0] = ctrl_reg;
      end else if (rd_stat) begin
         rdata_next[5:0] = status;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ctrl_reg <= bsps_pkg::CTRL_RESET;
         rdata_reg <= bsps_pkg::RDATA_ZERO;
         half_reg <= 1'b0;
         set_reg <= 1'b1; // coils float in reset, same as under set
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= reg_wdata_in[1:0];
         end
         rdata_reg <= rdata_next;
         half_reg <= step_size_sel_in;
         set_reg <= set_active;
      end
   end

   ////////////////////////////////////////////////////////////
   // outputs straight from flops
   assign coil_a_out_p_out = coil_a_reg.p;
   assign coil_a_out_n_out = coil_a_reg.n;
   assign coil_b_out_p_out = coil_b_reg.p;
   assign coil_b_out_n_out = coil_b_reg.n;
   assign home_phase_n_out = home_n_reg;
   assign home_phase_n_oe_out = home_reg; // open drain: drive only low
   assign drive_reduced_out = reduced_reg;
   assign reg_rdata_out = rdata_reg;

   ////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   wire logic odd_now;
   assign odd_now = phase_reg[0];

   property p_full_fwd;
      step_edge && !step_size_sel_in && !rotation_dir_in && !phase_reg[0]
      |=> phase_reg == $past(phase_reg) + 3'h2;
   endproperty
   a_full_fwd: assert property (p_full_fwd) else $error("full step missed"); // RULE1

   property p_half_fwd;
      step_edge && step_size_sel_in && !rotation_dir_in
      |=> phase_reg == $past(phase_reg) + 3'h1;
   endproperty
   a_half_fwd: assert property (p_half_fwd) else $error("half step missed"); // RULE4

   property p_back;
      step_edge && step_size_sel_in && rotation_dir_in
      |=> phase_reg == $past(phase_reg) - 3'h1;
   endproperty
   a_back: assert property (p_back) else $error("reverse step wrong"); // RULE18

   property p_full_even;
      !step_size_sel_in && !set_active && !phase_reg[0]
      && !bias_set_open_in ##1 step_edge && !step_size_sel_in
      |=> !phase_reg[0];
   endproperty
   a_full_even: assert property (p_full_even) else $error("odd phase in full mode"); // RULE2

   property p_both_coils;
      !set_reg && !odd_now
      |-> coil_a_reg.p != coil_a_reg.n && coil_b_reg.p != coil_b_reg.n;
   endproperty
   a_both_coils: assert property (p_both_coils) else $error("coil idle in full phase"); // RULE3

   property p_one_idle;
      !set_reg && odd_now
      |-> (coil_a_reg.p == coil_a_reg.n) != (coil_b_reg.p == coil_b_reg.n);
   endproperty
   a_one_idle: assert property (p_one_idle) else $error("odd phase not one coil"); // RULE7

   property p_hiz;
      !set_active && !idle_coil_impedance_sel_in && phase_next[0]
      |=> (coil_a_reg == '0) || (coil_b_reg == '0);
   endproperty
   a_hiz: assert property (p_hiz) else $error("idle coil not floated"); // RULE8

   property p_lowz;
      !set_active && idle_coil_impedance_sel_in && phase_next[0]
      |=> (coil_a_reg == 4'hA) || (coil_b_reg == 4'hA);
   endproperty
   a_lowz: assert property (p_lowz) else $error("idle coil not low z"); // RULE9

   property p_no_shoot;
      !(coil_a_reg.p == 2'h3 || coil_a_reg.n == 2'h3
        || coil_b_reg.p == 2'h3 || coil_b_reg.n == 2'h3);
   endproperty
   a_no_shoot: assert property (p_no_shoot) else $error("both switches on"); // RULE10

   property p_set;
      set_active |=> phase_reg == 3'h0 && coil_a_reg == '0
         && coil_b_reg == '0 && home_phase_n_oe_out;
   endproperty
   a_set: assert property (p_set) else $error("set did not preset"); // RULE11

   property p_ignore;
      set_active [*2] |=> $stable(phase_reg);
   endproperty
   a_ignore: assert property (p_ignore) else $error("control acted during set"); // RULE12

   property p_release;
      set_active ##1 !set_active && !step_edge
      |=> coil_a_reg == 4'h9 && coil_b_reg == 4'h9;
   endproperty
   a_release: assert property (p_release) else $error("release not in phase A"); // RULE13

   property p_standby;
      standby && !step_edge && !set_active |=> $stable(phase_reg) && drive_reduced_out;
   endproperty
   a_standby: assert property (p_standby) else $error("standby moved phase"); // RULE14

   property p_edge_only;
      !step_edge && !set_active |=> $stable(phase_reg);
   endproperty
   a_edge_only: assert property (p_edge_only) else $error("phase moved without edge"); // RULE16

   property p_home;
      home_phase_n_oe_out == (phase_reg == 3'h0);
   endproperty
   a_home: assert property (p_home) else $error("home indicator wrong"); // RULE17

   property p_nearest;
      step_edge && !step_size_sel_in && phase_reg[0] && !rotation_dir_in
      |=> phase_reg == $past(phase_reg) + 3'h1;
   endproperty
   a_nearest: assert property (p_nearest) else $error("mode change not nearest"); // RULE20

   property p_nearest_back;
      step_edge && !step_size_sel_in && phase_reg[0] && rotation_dir_in
      |=> phase_reg == $past(phase_reg) - 3'h1;
   endproperty
   a_nearest_back: assert property (p_nearest_back) else $error("mode change not nearest back"); // RULE20

   property p_full_back;
      step_edge && !step_size_sel_in && rotation_dir_in && !phase_reg[0]
      |=> phase_reg == $past(phase_reg) - 3'h2;
   endproperty
   a_full_back: assert property (p_full_back) else $error("full reverse step wrong"); // RULE18

   property p_home_pin;
      home_phase_n_out != home_phase_n_oe_out;
   endproperty
   a_home_pin: assert property (p_home_pin) else $error("home pin and enable disagree"); // RULE17

   // main scenarios
   c_full_wrap: cover property (step_edge && !step_size_sel_in && phase_reg == 3'h6
      && !rotation_dir_in ##1 phase_reg == 3'h0);
   c_half_odd: cover property (step_edge && step_size_sel_in ##1 odd_now);
   c_set_release: cover property (set_active ##1 !set_active);
   c_standby: cover property (standby && step_edge);
   c_full_back: cover property (step_edge && !step_size_sel_in && rotation_dir_in ##1 !odd_now);

endmodule : bsps_sequencer

// [bsps_sequencer_tb.sv]
/*
 * Self-checking bench for the phase sequencer: steps, modes, set,
 * standby and register port. Assumes the host model drives the
 * step clock and bias/set open level.
 */
module bsps_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic dir = 1'b0;
   logic size = 1'b0;
   logic imp = 1'b0;
   logic stby = 1'b0;
   logic step_req = 1'b0;
   logic open_req = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic step_clk, bias_open, busy, home_n, home_oe, reduced;
   bsps_pkg::bsps_drive_s a_p, a_n, b_p, b_n;
   logic [31:0] rdata;
   int mismatches = 0;
   int total_checks = 0;
   int ph = 0;
   bit open_now = 1'b1;

   always #12.5 clock_in = ~clock_in;

   bsps_host_model host (.clock_in(clock_in), .step_req_in(step_req), .open_req_in(open_req),
      .step_clk_out(step_clk), .bias_set_open_out(bias_open), .busy_out(busy));

   bsps_sequencer DUT (.clock_in(clock_in), .rst_in(rst_in), .step_clk_in(step_clk),
      .rotation_dir_in(dir), .step_size_sel_in(size), .idle_coil_impedance_sel_in(imp),
      .bias_set_open_in(bias_open), .bias_set_standby_in(stby), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .coil_a_out_p_out(a_p),
      .coil_a_out_n_out(a_n), .coil_b_out_p_out(b_p), .coil_b_out_n_out(b_n),
      .home_phase_n_out(home_n), .home_phase_n_oe_out(home_oe),
      .drive_reduced_out(reduced), .reg_rdata_out(rdata));

   ////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask : check

   // + is 4'h9 (p high, n low), - is 4'h6; odd phases rest one coil
   function automatic logic [7:0] coil_exp(input int p, input logic z);
      logic [3:0] ca, cb, rest;
      rest = z ? 4'hA : 4'h0;
      ca = (p / 2 == 0 || p / 2 == 3) ? 4'h9 : 4'h6;
      cb = (p / 2 < 2) ? 4'h9 : 4'h6;
      if (p % 2 == 1 && (p / 2) % 2 == 0) ca = rest;
      if (p % 2 == 1 && (p / 2) % 2 == 1) cb = rest;
      return {ca, cb};
   endfunction : coil_exp

   task automatic check_pins();
      check("coils", {24'h0, open_now ? 8'h00 : coil_exp(ph, imp)}, {24'h0, a_p, a_n, b_p, b_n});
      check("home", {30'h0, ph != 0 && !open_now, ph == 0 || open_now}, {30'h0, home_n, home_oe});
   endtask : check_pins

   // one step pulse; bounded wait on the model's busy flag
   task automatic step();
      int i;
      @(posedge clock_in) step_req <= 1'b1;
      @(posedge clock_in) step_req <= 1'b0;
      // let the model's busy flag settle before the first look
      #1;
      for (i = 0; i < 10 && busy !== 1'b0; i++) begin
         @(posedge clock_in);
         #1;
      end
      if (busy !== 1'b0) begin
         mismatches++;
         final_report();
      end
      if (!open_now && size) ph = (ph + (dir ? 7 : 1)) % 8;
      else if (!open_now) ph = (ph + (ph % 2 ? (dir ? 7 : 1) : (dir ? 6 : 2))) % 8;
      check_pins();
   endtask : step

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_in);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock_in) wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clock_in);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock_in) rd <= 1'b0;
      #1;
      check("rdata", exp, rdata);
   endtask : reg_rd

   task automatic settle(input logic o);
      @(posedge clock_in) open_req <= o;
      repeat (3) @(posedge clock_in);
      #1;
      open_now = o;
      check_pins();
   endtask : settle

   ////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      settle(1'b1);
      step();
      settle(1'b0);
      $display("test set done");
      repeat (4) step();
      @(posedge clock_in) dir <= 1'b1;
      repeat (4) step();
      $display("test full done");
      @(posedge clock_in);
      size <= 1'b1;
      dir <= 1'b0;
      repeat (8) step();
      @(posedge clock_in);
      imp <= 1'b1;
      dir <= 1'b1;
      repeat (8) step();
      $display("test half done");
      @(posedge clock_in) dir <= 1'b0;
      step();
      @(posedge clock_in) size <= 1'b0;
      step();
      reg_rd(bsps_pkg::STATUS_OFS, 32'h0000_0002);
      $display("test mode done");
      @(posedge clock_in) stby <= 1'b1;
      repeat (2) @(posedge clock_in);
      #1;
      check("reduced", 32'h1, {31'h0, reduced});
      check_pins();
      reg_rd(bsps_pkg::STATUS_OFS, 32'h0000_0022);
      @(posedge clock_in) stby <= 1'b0;
      reg_wr(bsps_pkg::CTRL_OFS, 32'h0000_0002);
      reg_rd(bsps_pkg::CTRL_OFS, 32'h0000_0002);
      check("soft stby", 32'h1, {31'h0, reduced});
      reg_wr(bsps_pkg::CTRL_OFS, 32'h0000_0000);
      reg_wr(4'hC, 32'h0000_0003);
      reg_rd(4'h8, 32'h0000_0000);
      reg_rd(bsps_pkg::CTRL_OFS, 32'h0000_0000);
      check("stby off", 32'h0, {31'h0, reduced});
      $display("test standby done");
      @(posedge clock_in);
      size <= 1'b1;
      imp <= 1'b0;
      step();
      settle(1'b1);
      step();
      reg_rd(bsps_pkg::STATUS_OFS, 32'h0000_0018);
      ph = 0;
      settle(1'b0);
      step();
      reg_wr(bsps_pkg::CTRL_OFS, 32'h0000_0001);
      // soft set floats the coils although the bias pin stays closed
      open_now = 1'b1;
      repeat (3) @(posedge clock_in);
      #1;
      check_pins();
      reg_rd(bsps_pkg::STATUS_OFS, 32'h0000_0018);
      ph = 0;
      reg_wr(bsps_pkg::CTRL_OFS, 32'h0000_0000);
      settle(1'b0);
      $display("test reset paths done");
      final_report();
   end
endmodule : bsps_sequencer_tb
